// [logic/fgp_params.svh]
// register offsets, reset values and timing counts of the flag and gpio ports
`ifndef FGP_PARAMS_SVH
`define FGP_PARAMS_SVH
`define FGP_ADDR_W 8
`define FGP_FLAG_DATA 8'h00
`define FGP_FLAG_CLR 8'h04
`define FGP_FLAG_SET 8'h08
`define FGP_FLAG_TGL 8'h0c
`define FGP_MASK_CLR 8'h10
`define FGP_MASK_SET 8'h14
`define FGP_FLAG_DIR 8'h18
`define FGP_FLAG_EDGE 8'h1c
`define FGP_FLAG_BOTH 8'h20
`define FGP_FLAG_LATCH 8'h24
`define FGP_PC_BASE 8'h40
`define FGP_PD_BASE 8'h60
`define FGP_PE_BASE 8'h80
`define FGP_G_DATA 8'h00
`define FGP_G_CLR 8'h04
`define FGP_G_SET 8'h08
`define FGP_G_TGL 8'h0c
`define FGP_G_DIR 8'h10
`define FGP_PC_CTRL 8'ha0
`define FGP_PC_CTRL_OWN 0
`define FGP_PC_CTRL_STRAP 1
`define FGP_RST_LOW 1'b0
`define FGP_PC_ODRAIN 10'h012
`define FGP_PC_UPPER 10'h3f0
`define FGP_STRAP_WAIT 2'h2
`endif

// [logic/fgp_pkg.sv]
// types shared by the flag and gpio port logic
package fgp_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fgp_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fgp_apb_rsp_t;

  typedef struct packed {
    logic set;
    logic clr;
    logic tgl;
    logic dir;
    logic [15:0] wd;
  } fgp_gwr_t;
endpackage

// [logic/fgp_gport.sv]
// one polled general-purpose port: direction, write-one data and sync
`timescale 1ns/1ns
`include "fgp_params.svh"
module fgp_gport #(
  parameter int W = 10,
  parameter logic [W-1:0] OD_MASK = '0
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // register writes
  input wire fgp_pkg::fgp_gwr_t i_wr,
  input wire logic [W-1:0] i_block,
  // pins
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_out,
  output logic [W-1:0] o_oe,
  // read side
  output logic [W-1:0] o_rdata
);
  import fgp_pkg::*;

  generate
    if (W < 1 || W > 16) begin : g_bad_w
      $error("port width must be 1 to 16");
    end
  endgenerate

  logic [W-1:0] dir_reg;
  logic [W-1:0] data_reg;
  logic [W-1:0] sync1_reg;
  logic [W-1:0] sync2_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] oe_reg;
  logic [W-1:0] wd;
  logic [W-1:0] data_next;
  logic [W-1:0] dir_next;

  assign wd = i_wr.wd[W-1:0];
  assign data_next = i_wr.set ? (data_reg | wd) :
                     i_wr.clr ? (data_reg & ~wd) :
                     i_wr.tgl ? (data_reg ^ wd) : data_reg;
  assign dir_next = i_wr.dir ? wd : dir_reg;
  assign o_rdata = (sync2_reg & ~dir_reg) | (data_reg & dir_reg);
  assign o_out = out_reg;
  assign o_oe = oe_reg;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dir_reg <= {W{`FGP_RST_LOW}};
      data_reg <= {W{`FGP_RST_LOW}};
      sync1_reg <= {W{`FGP_RST_LOW}};
      sync2_reg <= {W{`FGP_RST_LOW}};
      out_reg <= {W{`FGP_RST_LOW}};
      oe_reg <= {W{`FGP_RST_LOW}};
    end else begin
      dir_reg <= dir_next;
      data_reg <= data_next;
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
      out_reg <= data_next & ~OD_MASK;
      oe_reg <= dir_next & ~i_block & ~(OD_MASK & data_next);
    end
  end
endmodule

// [logic/fgp_top.sv]
// flag port with interrupts and three polled gpio ports behind apb
`timescale 1ns/1ns
`include "fgp_params.svh"
// Functional notes
// - sixteen bidirectional software-controlled flag pins
// - per-pin flag direction register
// - flag set, clear, toggle writes touch only one bits
// - set register drives written flags high
// - clear register drives written flags low
// - toggle register inverts written flags
// - direct write sets whole flag vector
// - data read returns sensed flag pins
// - mask set enables chosen flag interrupts
// - mask clear disables chosen flag interrupts
// - input activity or output change interrupts
// - per-pin level or edge sensitivity
// - edge mode picks rising or both
// - pin sharing conflicts avoided by software
// - thirty-eight gpio pins in three ports
// - gpio ports never interrupt, polled only
// - per-pin direction for each gpio port
// - gpio set, clear, toggle writes touch only one bits
// - port c bits one, four open-drain
// - gpio set, clear, toggle, direction registers
// - gpio data read returns input pins, data register for output pins
// - strap picks port c upper function
module fgp_top #(
  parameter int FLAG_W = 16,
  parameter int PC_W = 10,
  parameter int PD_W = 14,
  parameter int PE_W = 14
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // apb slave
  input wire fgp_pkg::fgp_apb_req_t i_apb,
  output fgp_pkg::fgp_apb_rsp_t o_apb,
  // flag pins
  input wire logic [FLAG_W-1:0] i_flag_pin_vector,
  output logic [FLAG_W-1:0] o_flag_pin_vector_out,
  output logic [FLAG_W-1:0] o_flag_pin_vector_oe,
  output logic o_flag_irq,
  // port c, d, e pins
  input wire logic [PC_W-1:0] i_port_c_pin,
  output logic [PC_W-1:0] o_port_c_out,
  output logic [PC_W-1:0] o_port_c_oe,
  input wire logic [PD_W-1:0] i_port_d_pin,
  output logic [PD_W-1:0] o_port_d_out,
  output logic [PD_W-1:0] o_port_d_oe,
  input wire logic [PE_W-1:0] i_port_e_pin,
  output logic [PE_W-1:0] o_port_e_out,
  output logic [PE_W-1:0] o_port_e_oe,
  // port c upper group function
  input wire logic i_port_c_function_strap,
  output logic o_port_c_upper_media
);
  import fgp_pkg::*;

  generate
    if (FLAG_W < 1 || FLAG_W > 16) begin : g_bad_flag
      $error("flag width must be 1 to 16");
    end
    if (PC_W != 10) begin : g_bad_pc
      $error("port c must be 10 pins wide");
    end
    if (PC_W + PD_W + PE_W != 38) begin : g_bad_gpio
      $error("gpio ports must total 38 pins");
    end
  endgenerate

  // apb decode
  logic [7:0] addr;
  logic [15:0] wd16;
  logic setup;
  logic fire;
  logic wr;
  logic hit_fdata;
  logic hit_fclr;
  logic hit_fset;
  logic hit_ftgl;
  logic hit_mclr;
  logic hit_mset;
  logic hit_fdir;
  logic hit_fedge;
  logic hit_fboth;
  logic hit_flatch;
  logic hit_pcctrl;
  logic hit_pc;
  logic hit_pd;
  logic hit_pe;
  logic mapped;
  fgp_apb_rsp_t rsp_reg;
  fgp_apb_rsp_t rsp_next;
  logic [31:0] rdata;

  assign addr = i_apb.paddr;
  assign wd16 = i_apb.pwdata[15:0];
  // access cycle seen but answer not yet given
  assign setup = i_apb.psel & i_apb.penable & ~rsp_reg.pready;
  // a write acts only on the edge that sees pready high
  assign fire = i_apb.psel & i_apb.penable & rsp_reg.pready;
  assign wr = fire & i_apb.pwrite;

  assign hit_fdata = addr == `FGP_FLAG_DATA;
  assign hit_fclr = addr == `FGP_FLAG_CLR;
  assign hit_fset = addr == `FGP_FLAG_SET;
  assign hit_ftgl = addr == `FGP_FLAG_TGL;
  assign hit_mclr = addr == `FGP_MASK_CLR;
  assign hit_mset = addr == `FGP_MASK_SET;
  assign hit_fdir = addr == `FGP_FLAG_DIR;
  assign hit_fedge = addr == `FGP_FLAG_EDGE;
  assign hit_fboth = addr == `FGP_FLAG_BOTH;
  assign hit_flatch = addr == `FGP_FLAG_LATCH;
  assign hit_pcctrl = addr == `FGP_PC_CTRL;

  // gpio port decode
  fgp_gwr_t pc_wr;
  fgp_gwr_t pd_wr;
  fgp_gwr_t pe_wr;
  logic [7:0] pc_off;
  logic [7:0] pd_off;
  logic [7:0] pe_off;
  logic [PC_W-1:0] pc_rdata;
  logic [PD_W-1:0] pd_rdata;
  logic [PE_W-1:0] pe_rdata;
  logic [PC_W-1:0] pc_block;

  assign pc_off = addr - `FGP_PC_BASE;
  assign pd_off = addr - `FGP_PD_BASE;
  assign pe_off = addr - `FGP_PE_BASE;
  assign hit_pc = addr >= `FGP_PC_BASE && pc_off <= `FGP_G_DIR &&
                  pc_off[1:0] == 2'h0;
  assign hit_pd = addr >= `FGP_PD_BASE && pd_off <= `FGP_G_DIR &&
                  pd_off[1:0] == 2'h0;
  assign hit_pe = addr >= `FGP_PE_BASE && pe_off <= `FGP_G_DIR &&
                  pe_off[1:0] == 2'h0;
  assign mapped = hit_fdata | hit_fclr | hit_fset | hit_ftgl | hit_mclr |
                  hit_mset | hit_fdir | hit_fedge | hit_fboth | hit_flatch |
                  hit_pcctrl | hit_pc | hit_pd | hit_pe;

  assign pc_wr.set = wr & hit_pc & (pc_off == `FGP_G_SET);
  assign pc_wr.clr = wr & hit_pc & (pc_off == `FGP_G_CLR);
  assign pc_wr.tgl = wr & hit_pc & (pc_off == `FGP_G_TGL);
  assign pc_wr.dir = wr & hit_pc & (pc_off == `FGP_G_DIR);
  assign pc_wr.wd = wd16;
  assign pd_wr.set = wr & hit_pd & (pd_off == `FGP_G_SET);
  assign pd_wr.clr = wr & hit_pd & (pd_off == `FGP_G_CLR);
  assign pd_wr.tgl = wr & hit_pd & (pd_off == `FGP_G_TGL);
  assign pd_wr.dir = wr & hit_pd & (pd_off == `FGP_G_DIR);
  assign pd_wr.wd = wd16;
  assign pe_wr.set = wr & hit_pe & (pe_off == `FGP_G_SET);
  assign pe_wr.clr = wr & hit_pe & (pe_off == `FGP_G_CLR);
  assign pe_wr.tgl = wr & hit_pe & (pe_off == `FGP_G_TGL);
  assign pe_wr.dir = wr & hit_pe & (pe_off == `FGP_G_DIR);
  assign pe_wr.wd = wd16;

  // flag registers
  logic [FLAG_W-1:0] fwd;
  logic [FLAG_W-1:0] fdata_reg;
  logic [FLAG_W-1:0] fdata_next;
  logic [FLAG_W-1:0] fdir_reg;
  logic [FLAG_W-1:0] fdir_next;
  logic [FLAG_W-1:0] mask_reg;
  logic [FLAG_W-1:0] mask_next;
  logic [FLAG_W-1:0] edge_reg;
  logic [FLAG_W-1:0] both_reg;
  logic [FLAG_W-1:0] fsync1_reg;
  logic [FLAG_W-1:0] fsync2_reg;
  logic [FLAG_W-1:0] fprev_reg;
  logic [FLAG_W-1:0] latch_reg;
  logic [FLAG_W-1:0] latch_next;
  logic [FLAG_W-1:0] edge_hit;
  logic [FLAG_W-1:0] cond;
  logic irq_next;

  assign fwd = i_apb.pwdata[FLAG_W-1:0];
  assign fdata_next = (wr & hit_fset) ? (fdata_reg | fwd) :
                      (wr & hit_fclr) ? (fdata_reg & ~fwd) :
                      (wr & hit_ftgl) ? (fdata_reg ^ fwd) :
                      (wr & hit_fdata) ? fwd : fdata_reg;
  assign fdir_next = (wr & hit_fdir) ? fwd : fdir_reg;
  assign mask_next = (wr & hit_mset) ? (mask_reg | fwd) :
                     (wr & hit_mclr) ? (mask_reg & ~fwd) : mask_reg;
  assign edge_hit = (fsync2_reg & ~fprev_reg) |
                    (both_reg & ~fsync2_reg & fprev_reg);
  // clearing a flag also clears its edge latch; a new edge wins
  assign latch_next = (latch_reg & ~({FLAG_W{wr & hit_fclr}} & fwd)) |
                      (edge_hit & edge_reg);
  // level or edge condition per pin
  // output flags read back, so software changes also fire
  assign cond = (edge_reg & latch_reg) | (~edge_reg & fsync2_reg);
  assign irq_next = |(mask_reg & cond);

  // port c upper group ownership from the strap
  logic strap1_reg;
  logic strap2_reg;
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg;
  logic strap_val_reg;
  logic media_reg;
  logic media_next;
  logic strap_take;

  assign strap_take = ~strap_done_reg && strap_cnt_reg == `FGP_STRAP_WAIT;
  // strap high locks gpio; low starts media, writable
  assign media_next = strap_take ? ~strap2_reg :
                      (wr & hit_pcctrl & strap_done_reg & ~strap_val_reg) ?
                      i_apb.pwdata[`FGP_PC_CTRL_OWN] : media_reg;
  // block from the next owner so drivers never lag the media flag
  assign pc_block = media_next ? `FGP_PC_UPPER : {PC_W{`FGP_RST_LOW}};

  // read data selection
  logic [31:0] g_rdata;
  logic [31:0] f_rdata;

  assign f_rdata = hit_fdata ? 32'(fsync2_reg) :
                   (hit_fclr | hit_fset | hit_ftgl) ? 32'(fdata_reg) :
                   (hit_mclr | hit_mset) ? 32'(mask_reg) :
                   hit_fdir ? 32'(fdir_reg) :
                   hit_fedge ? 32'(edge_reg) :
                   hit_fboth ? 32'(both_reg) :
                   hit_flatch ? 32'(latch_reg) : 32'h0000_0000;
  assign g_rdata = hit_pc ? 32'(pc_rdata) :
                   hit_pd ? 32'(pd_rdata) :
                   hit_pe ? 32'(pe_rdata) :
                   hit_pcctrl ? {30'h0000_0000, strap_val_reg, media_reg} :
                   32'h0000_0000;
  assign rdata = f_rdata | g_rdata;

  assign rsp_next.pready = setup;
  assign rsp_next.pslverr = setup & ~mapped;
  assign rsp_next.prdata = (setup & ~i_apb.pwrite & mapped) ? rdata :
                           32'h0000_0000;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fdata_reg <= {FLAG_W{`FGP_RST_LOW}};
      fdir_reg <= {FLAG_W{`FGP_RST_LOW}};
      mask_reg <= {FLAG_W{`FGP_RST_LOW}};
      edge_reg <= {FLAG_W{`FGP_RST_LOW}};
      both_reg <= {FLAG_W{`FGP_RST_LOW}};
      latch_reg <= {FLAG_W{`FGP_RST_LOW}};
    end else begin
      fdata_reg <= fdata_next;
      fdir_reg <= fdir_next;
      mask_reg <= mask_next;
      edge_reg <= (wr & hit_fedge) ? fwd : edge_reg;
      both_reg <= (wr & hit_fboth) ? fwd : both_reg;
      latch_reg <= latch_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fsync1_reg <= {FLAG_W{`FGP_RST_LOW}};
      fsync2_reg <= {FLAG_W{`FGP_RST_LOW}};
      fprev_reg <= {FLAG_W{`FGP_RST_LOW}};
    end else begin
      fsync1_reg <= i_flag_pin_vector;
      fsync2_reg <= fsync1_reg;
      fprev_reg <= fsync2_reg;
    end
  end

  // sharing with other ports left to software
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flag_pin_vector_out <= {FLAG_W{`FGP_RST_LOW}};
      o_flag_pin_vector_oe <= {FLAG_W{`FGP_RST_LOW}};
      o_flag_irq <= `FGP_RST_LOW;
    end else begin
      o_flag_pin_vector_out <= fdata_next;
      o_flag_pin_vector_oe <= fdir_next;
      o_flag_irq <= irq_next;
    end
  end

  // strap caught by clocked logic after reset release
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      strap1_reg <= 1'b0;
      strap2_reg <= 1'b0;
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_val_reg <= 1'b0;
      media_reg <= 1'b0;
    end else begin
      strap1_reg <= i_port_c_function_strap;
      strap2_reg <= strap1_reg;
      if (!strap_done_reg) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (strap_take) begin
        strap_done_reg <= 1'b1;
        strap_val_reg <= strap2_reg;
      end
      media_reg <= media_next;
    end
  end

  assign o_apb = rsp_reg;
  assign o_port_c_upper_media = media_reg;

  // gpio ports have no interrupt path
  fgp_gport #(
    .W(PC_W),
    .OD_MASK(`FGP_PC_ODRAIN)
  ) u_port_c (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_wr(pc_wr),
    .i_block(pc_block),
    .i_pin(i_port_c_pin),
    .o_out(o_port_c_out),
    .o_oe(o_port_c_oe),
    .o_rdata(pc_rdata)
  );

  fgp_gport #(
    .W(PD_W),
    .OD_MASK({PD_W{1'b0}})
  ) u_port_d (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_wr(pd_wr),
    .i_block({PD_W{1'b0}}),
    .i_pin(i_port_d_pin),
    .o_out(o_port_d_out),
    .o_oe(o_port_d_oe),
    .o_rdata(pd_rdata)
  );

  fgp_gport #(
    .W(PE_W),
    .OD_MASK({PE_W{1'b0}})
  ) u_port_e (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_wr(pe_wr),
    .i_block({PE_W{1'b0}}),
    .i_pin(i_port_e_pin),
    .o_out(o_port_e_out),
    .o_oe(o_port_e_oe),
    .o_rdata(pe_rdata)
  );
endmodule

// [test/fgp_pin_model.sv]
// pin resolution between design drivers and the external circuit
`timescale 1ns/1ns
module fgp_pin_model #(
  parameter int W = 16
) (
  // design side
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe,
  // external circuit
  input wire logic [W-1:0] i_ext,
  output logic [W-1:0] o_pin
);
  // the outside circuit yields to the device wherever the device drives
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// [test/fgp_top_assertions.sv]
// concurrent checks on the flag and gpio port top
`timescale 1ns/1ns
`include "fgp_params.svh"
module fgp_top_assertions #(
  parameter int FLAG_W = 16,
  parameter int PC_W = 10,
  parameter int PE_W = 14
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // apb
  input wire fgp_pkg::fgp_apb_req_t i_apb,
  input wire fgp_pkg::fgp_apb_rsp_t o_apb,
  // pins
  input wire logic [FLAG_W-1:0] o_flag_pin_vector_out,
  input wire logic [FLAG_W-1:0] o_flag_pin_vector_oe,
  input wire logic o_flag_irq,
  input wire logic [PC_W-1:0] o_port_c_out,
  input wire logic [PC_W-1:0] o_port_c_oe,
  input wire logic [PE_W-1:0] o_port_e_out,
  input wire logic o_port_c_upper_media
);
  import fgp_pkg::*;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  wire logic tk = i_apb.psel & i_apb.penable & i_apb.pwrite & o_apb.pready;
  wire logic [FLAG_W-1:0] wd = i_apb.pwdata[FLAG_W-1:0];
  wire logic [FLAG_W-1:0] fo = o_flag_pin_vector_out;
  // a write counts only at the edge that completes it
  sequence wr(logic [7:0] a);
    tk && i_apb.paddr == a;
  endsequence
  flag_dir_a: assert property (
    wr(`FGP_FLAG_DIR) |=> o_flag_pin_vector_oe == $past(wd))
    else $error("flag direction not applied");
  flag_set_a: assert property (
    wr(`FGP_FLAG_SET) |=> fo == ($past(fo) | $past(wd)))
    else $error("flag set wrong");
  flag_clr_a: assert property (
    wr(`FGP_FLAG_CLR) |=> fo == ($past(fo) & ~$past(wd)))
    else $error("flag clear wrong");
  flag_tgl_a: assert property (
    wr(`FGP_FLAG_TGL) |=> fo == ($past(fo) ^ $past(wd)))
    else $error("flag toggle wrong");
  flag_direct_a: assert property (
    wr(`FGP_FLAG_DATA) |=> fo == $past(wd))
    else $error("flag direct write wrong");
  mask_off_a: assert property (
    wr(`FGP_MASK_CLR) ##0 (wd == 16'hffff) |-> ##2 !o_flag_irq)
    else $error("irq with all masks cleared");
  reset_idle_a: assert property (
    $rose(i_nrst) |-> fo == 0 && o_flag_pin_vector_oe == 0 && !o_flag_irq)
    else $error("outputs not idle after reset");
  open_drain_a: assert property (
    o_port_c_out[1] == 1'b0 && o_port_c_out[4] == 1'b0)
    else $error("open drain pin driven high");
  media_hold_a: assert property (
    o_port_c_upper_media |-> o_port_c_oe[9:4] == 6'h00)
    else $error("gpio drives media pins");
  gpio_set_a: assert property (
    wr(8'h88) |=> o_port_e_out ==
      ($past(o_port_e_out) | $past(i_apb.pwdata[PE_W-1:0])))
    else $error("gpio set wrong");
endmodule
bind fgp_top fgp_top_assertions #(.FLAG_W(FLAG_W), .PC_W(PC_W),
  .PE_W(PE_W)) u_fgp_top_assertions (.*);

// [test/testbench.sv]
// self-checking bench for the flag and gpio port top
`timescale 1ns/1ns
`include "fgp_params.svh"
module testbench;
  import fgp_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic strap = 1'b0;
  fgp_apb_req_t req = '0;
  fgp_apb_rsp_t rsp;
  logic [15:0] fx = '0, fo, fe, fp;
  logic [9:0] cx = '0, co, ce, cp;
  logic [13:0] dx = '0, dd, de, dp, ex = '0, eo, ee, ep;
  logic [31:0] rd, d, dr;
  logic [15:0] fv, gv, m, x, wm, od;
  logic er, irq, media;
  logic [7:0] fa [4] = '{`FGP_FLAG_DATA, `FGP_FLAG_SET, `FGP_FLAG_CLR,
    `FGP_FLAG_TGL};
  logic [7:0] ga [3] = '{`FGP_G_SET, `FGP_G_CLR, `FGP_G_TGL};
  logic [7:0] gb [3] = '{`FGP_PC_BASE, `FGP_PD_BASE, `FGP_PE_BASE};
  logic [7:0] ra [5] = '{`FGP_FLAG_CLR, `FGP_MASK_SET, `FGP_FLAG_DIR,
    `FGP_FLAG_EDGE, `FGP_FLAG_BOTH};
  int n_fail = 0, total_checks = 0, op, b;

  always #4 i_sys_clk = ~i_sys_clk;

  fgp_top u_fgp_top (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_apb(req), .o_apb(rsp),
    .i_flag_pin_vector(fp), .o_flag_pin_vector_out(fo),
    .o_flag_pin_vector_oe(fe), .o_flag_irq(irq),
    .i_port_c_pin(cp), .o_port_c_out(co), .o_port_c_oe(ce),
    .i_port_d_pin(dp), .o_port_d_out(dd), .o_port_d_oe(de),
    .i_port_e_pin(ep), .o_port_e_out(eo), .o_port_e_oe(ee),
    .i_port_c_function_strap(strap), .o_port_c_upper_media(media));
  fgp_pin_model #(.W(16)) u_fgp_pin_model_f (.i_out(fo), .i_oe(fe),
    .i_ext(fx), .o_pin(fp));
  fgp_pin_model #(.W(10)) u_fgp_pin_model_c (.i_out(co), .i_oe(ce),
    .i_ext(cx), .o_pin(cp));
  fgp_pin_model #(.W(14)) u_fgp_pin_model_d (.i_out(dd), .i_oe(de),
    .i_ext(dx), .o_pin(dp));
  fgp_pin_model #(.W(14)) u_fgp_pin_model_e (.i_out(eo), .i_oe(ee),
    .i_ext(ex), .o_pin(ep));

  function automatic logic [15:0] fnext(input int o,
      input logic [15:0] v, input logic [15:0] w);
    case (o)
      0: return w;
      1: return v | w;
      2: return v & ~w;
      default: return v ^ w;
    endcase
  endfunction
  // outputs read back their value, inputs the outside level
  function automatic logic [15:0] res(input logic [15:0] e, v, w);
    return (e & v) | (~e & w);
  endfunction

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // request held until the edge that sees pready high; data taken there
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] v);
    int k;
    k = 0;
    req <= '{1'b1, 1'b0, w, a, v};
    @(posedge i_sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    if (rsp.pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge i_sys_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wirq(input logic v);
    int k;
    k = 0;
    do begin
      @(negedge i_sys_clk);
      k++;
    end while (irq !== v && k < 12);
    chk(irq, v);
    if (irq !== v) begin
      end_sim();
    end
    @(posedge i_sys_clk);
  endtask

  initial begin
    void'($urandom(32'hbb3a1eba));
    pause(5);
    i_nrst <= 1'b1;
    pause(5);
    foreach (ra[i]) rdc(ra[i], 32'h0);
    rdc(8'hfc, 32'h0);
    chk(er, 1'b1);
    $display("test reset done");
    fv = '0;
    for (int i = 0; i < 40; i++) begin
      op = i < 4 ? i : $urandom_range(3);
      d = $urandom;
      apb(1'b1, fa[op], d);
      fv = fnext(op, fv, d[15:0]);
      chk(fo, fv);
      rdc(`FGP_FLAG_SET, fv);
    end
    for (int i = 0; i < 10; i++) begin
      dr = i == 0 ? 32'h0000ffff : $urandom;
      fx <= 16'($urandom);
      apb(1'b1, `FGP_FLAG_DIR, dr);
      chk(fe, dr[15:0]);
      pause(3);
      rdc(`FGP_FLAG_DATA, res(dr[15:0], fv, fx));
    end
    $display("test flag value done");
    fx <= '0;
    d = $urandom;
    dr = $urandom;
    apb(1'b1, `FGP_MASK_SET, d);
    apb(1'b1, `FGP_MASK_CLR, dr);
    rdc(`FGP_MASK_SET, d[15:0] & ~dr[15:0]);
    apb(1'b1, `FGP_MASK_CLR, 32'hffff);
    wirq(1'b0);
    b = $urandom_range(15);
    m = 16'h1 << b;
    apb(1'b1, `FGP_FLAG_DIR, 32'h0);
    apb(1'b1, `FGP_MASK_SET, m);
    fx[b] <= 1'b1;
    wirq(1'b1);
    fx[b] <= 1'b0;
    wirq(1'b0);
    apb(1'b1, `FGP_FLAG_EDGE, m);
    fx[b] <= 1'b1;
    wirq(1'b1);
    fx[b] <= 1'b0;
    pause(6);
    chk(irq, 1'b1);
    apb(1'b1, `FGP_FLAG_CLR, m);
    wirq(1'b0);
    fx[b] <= 1'b1;
    wirq(1'b1);
    apb(1'b1, `FGP_FLAG_CLR, m);
    fx[b] <= 1'b0;
    pause(6);
    chk(irq, 1'b0);
    apb(1'b1, `FGP_FLAG_BOTH, m);
    fx[b] <= 1'b1;
    wirq(1'b1);
    apb(1'b1, `FGP_FLAG_CLR, m);
    wirq(1'b0);
    fx[b] <= 1'b0;
    wirq(1'b1);
    apb(1'b1, `FGP_FLAG_CLR, m);
    wirq(1'b0);
    apb(1'b1, `FGP_FLAG_DIR, m);
    apb(1'b1, `FGP_FLAG_TGL, m);
    wirq(1'b1);
    apb(1'b1, `FGP_MASK_CLR, 32'hffff);
    wirq(1'b0);
    $display("test interrupt done");
    chk(media, 1'b1);
    rdc(`FGP_PC_CTRL, 32'h1);
    apb(1'b1, `FGP_PC_CTRL, 32'h0);
    chk(media, 1'b0);
    for (int p = 0; p < 3; p++) begin
      wm = p == 0 ? 16'h03ff : 16'h3fff;
      gv = '0;
      for (int i = 0; i < 12; i++) begin
        op = i < 3 ? i : $urandom_range(2);
        d = $urandom;
        dr = $urandom;
        {ex, dx, cx} <= 38'({$urandom, $urandom});
        apb(1'b1, gb[p] + `FGP_G_DIR, dr);
        apb(1'b1, gb[p] + ga[op], d);
        gv = fnext(op + 1, gv, d[15:0]) & wm;
        x = p == 0 ? 16'(cx) : p == 1 ? 16'(dx) : 16'(ex);
        rdc(gb[p], res(dr[15:0], gv, x) & wm);
        od = p == 0 ? 16'(`FGP_PC_ODRAIN) : 16'h0000;
        x = p == 0 ? 16'(ce) : p == 1 ? 16'(de) : 16'(ee);
        chk(x, dr[15:0] & wm & ~(gv & od));
        x = p == 0 ? 16'(co) : p == 1 ? 16'(dd) : 16'(eo);
        chk(x, gv & ~od);
      end
    end
    $display("test gpio done");
    strap <= 1'b1;
    i_nrst <= 1'b0;
    pause(5);
    i_nrst <= 1'b1;
    pause(6);
    apb(1'b1, `FGP_PC_CTRL, 32'h1);
    rdc(`FGP_PC_CTRL, 32'h2);
    chk(media, 1'b0);
    $display("test strap done");
    end_sim();
  end
endmodule
